// file: abc_regs.vh
// Constants for the converter bus control block.
// Assumes a 100 MHz system clock.
`ifndef ABC_REGS_VH
`define ABC_REGS_VH

`define ABC_CLK_PERIOD_NS   10
`define ABC_CONV8_MAX_US    24
`define ABC_CONV12_MAX_US   35
// Longest times round down to whole cycles
`define ABC_CONV8_CYCLES    ((`ABC_CONV8_MAX_US * 1000) / `ABC_CLK_PERIOD_NS)
`define ABC_CONV12_CYCLES   ((`ABC_CONV12_MAX_US * 1000) / `ABC_CLK_PERIOD_NS)
// Last counter value: busy stands for exactly the longest allowed time
`define ABC_CONV8_LAST      12'h95f
`define ABC_CONV12_LAST     12'hdab
`define ABC_CNT_W           12
`define ABC_RES_W           12
`define ABC_ST_IDLE         2'h0
`define ABC_ST_CONV         2'h1
`define ABC_ST_READ         2'h2
`define ABC_OE_OFF          12'h000
`define ABC_OE_WORD         12'hfff
`define ABC_OE_BYTE         12'hff0

`endif

// file: abc_sync.v
// Two-flop synchroniser for a group of pin inputs.
// Assumes inputs are asynchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module abc_sync #(
  parameter W = 1
) (
  input  wire         clk,
  input  wire         nrst,
  input  wire [W-1:0] d,
  output reg  [W-1:0] q
);
  reg [W-1:0] meta_r;

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      meta_r <= {W{1'b0}};
      q      <= {W{1'b0}};
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule
`default_nettype wire

// file: abc_ctrl.v
// Bus control of a successive-approximation converter: start decode,
// busy flag, timed conversion and three-state result read.
// Assumes host strobes are asynchronous pins; the analog result arrives
// as a parallel word that is sampled when conversion ends.
// Limitation: pins are seen two clocks late, and a strobe shorter than
// one clock period may be missed.
// Word mode and the byte address must stay steady through a read.
// Through reset busy is low and every data driver is off.
//
// Functional notes
// - Start when enable high, select low, read/convert low; either may trigger.
// - Read/convert high at enable performs a read and drives data.
// - Start commands ignored while busy, until conversion finishes.
// - Data drivers stay disabled for the whole conversion.
// - Drivers enabled only while enable, read/convert high and select low.
// - 8-bit cycle at most 24 us, 12-bit cycle at most 35 us.
// - Busy flag high during conversion, low otherwise.
// - Byte mode: address low gives 8 MSBs, high gives 4 LSBs plus zeros.
// - Word mode: all twelve result bits on twelve lines together.
`timescale 1ns/1ps
`default_nettype none
`include "abc_regs.vh"
module abc_ctrl (
  input  wire        clk,
  input  wire        nrst,
  input  wire        chip_en,
  input  wire        chip_sel_n,
  input  wire        read_conv,
  input  wire        byte_short_select,
  input  wire        word_mode,
  input  wire [11:0] analog_code,
  output wire        conv_busy_flag,
  output reg  [11:0] data_o,
  output wire [11:0] data_oe
);

  // ----------------------------------------
  // Pin synchronisation
  // ----------------------------------------
  // One synchroniser per pin; all share the same two-flop latency
  wire en_s;
  wire seln_s;
  wire rc_s;
  wire a0_s;
  wire wide_s;

  abc_sync #(.W(1)) u_sync_en (
    .clk  (clk),
    .nrst (nrst),
    .d    (chip_en),
    .q    (en_s)
  );

  abc_sync #(.W(1)) u_sync_sel (
    .clk  (clk),
    .nrst (nrst),
    .d    (chip_sel_n),
    .q    (seln_s)
  );

  abc_sync #(.W(1)) u_sync_rc (
    .clk  (clk),
    .nrst (nrst),
    .d    (read_conv),
    .q    (rc_s)
  );

  abc_sync #(.W(1)) u_sync_addr (
    .clk  (clk),
    .nrst (nrst),
    .d    (byte_short_select),
    .q    (a0_s)
  );

  abc_sync #(.W(1)) u_sync_wide (
    .clk  (clk),
    .nrst (nrst),
    .d    (word_mode),
    .q    (wide_s)
  );

  // ----------------------------------------
  // Command decode
  // ----------------------------------------
  // Both enables at their active level; start and read share it
  // Start takes the rise only, so a held strobe never restarts
  wire active    = en_s & ~seln_s;
  reg  active_d_r;
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      active_d_r <= 1'b0;
    end else begin
      active_d_r <= active;
    end
  end
  wire start_req = active & ~active_d_r & ~rc_s;

  // ----------------------------------------
  // Conversion timer and state
  // ----------------------------------------
  localparam [`ABC_CNT_W-1:0] C8  = `ABC_CONV8_LAST;
  localparam [`ABC_CNT_W-1:0] C12 = `ABC_CONV12_LAST;
  reg [1:0]            state_r;
  reg [1:0]            state_nxt;
  reg [`ABC_CNT_W-1:0] cnt_r;
  reg [`ABC_CNT_W-1:0] cnt_nxt;
  reg                  short_r;
  reg                  short_nxt;
  reg [11:0]           result_r;
  reg [11:0]           result_nxt;

  // last count fixed by the cycle kind chosen at start
  wire [`ABC_CNT_W-1:0] last_cnt = short_r ? C8 : C12;

  always @* begin
    state_nxt  = state_r;
    cnt_nxt    = cnt_r;
    short_nxt  = short_r;
    result_nxt = result_r;
    case (state_r)
      `ABC_ST_IDLE: begin
        if (start_req) begin
          state_nxt = `ABC_ST_CONV;
          cnt_nxt   = {`ABC_CNT_W{1'b0}};
          // Address level at start picks the short cycle
          short_nxt = a0_s;
        end
      end
      `ABC_ST_CONV: begin
        if (cnt_r == last_cnt) begin
          state_nxt  = `ABC_ST_IDLE;
          // Short cycle keeps only the upper eight bits
          result_nxt = short_r ? {analog_code[11:4], 4'h0} : analog_code;
        end else begin
          cnt_nxt = cnt_r + {{(`ABC_CNT_W-1){1'b0}}, 1'b1};
        end
      end
      default: begin
        // Spare codes fall back to idle
        state_nxt = `ABC_ST_IDLE;
      end
    endcase
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_r  <= `ABC_ST_IDLE;
      cnt_r    <= {`ABC_CNT_W{1'b0}};
      short_r  <= 1'b0;
      result_r <= 12'h000;
    end else begin
      state_r  <= state_nxt;
      cnt_r    <= cnt_nxt;
      short_r  <= short_nxt;
      result_r <= result_nxt;
    end
  end

  assign conv_busy_flag = (state_r == `ABC_ST_CONV);

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  // read window, gated by busy
  wire        reading = active & rc_s & ~conv_busy_flag;
  reg  [11:0] data_nxt;
  reg  [11:0] oe_nxt;
  reg  [11:0] oe_lines_r;

  // Data follows the pins every cycle, so it is settled when drivers turn on
  always @* begin
    if (wide_s) begin
      data_nxt = result_r;
    end else if (a0_s) begin
      // low nibble, trailing zeros below it
      data_nxt = {result_r[3:0], 8'h00};
    end else begin
      data_nxt = {result_r[11:4], 4'h0};
    end
  end

  // ----------------------------------------
  // Output enables
  // ----------------------------------------
  // drivers off when busy or strobe gone
  always @* begin
    oe_nxt = `ABC_OE_OFF;
    if (reading) begin
      if (wide_s) begin
        oe_nxt = `ABC_OE_WORD;
      end else begin
        // Byte mode drives the upper eight lines; lower four float
        oe_nxt = `ABC_OE_BYTE;
      end
    end
  end

  // Data and enables leave the same edge, both from flip-flops
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      oe_lines_r <= `ABC_OE_OFF;
      data_o     <= 12'h000;
    end else begin
      oe_lines_r <= oe_nxt;
      data_o     <= data_nxt;
    end
  end

  assign data_oe = oe_lines_r;

endmodule
`default_nettype wire

// file: abc_ctrl_sva.sv
// Port checker for the converter bus control block.
// Assumes one clock, clk, and an async active-low reset, nrst.
`timescale 1ns/1ps
`default_nettype none
module abc_ctrl_sva (
  input wire        clk,
  input wire        nrst,
  input wire        chip_en,
  input wire        chip_sel_n,
  input wire        read_conv,
  input wire        byte_short_select,
  input wire        word_mode,
  input wire [11:0] analog_code,
  input wire        conv_busy_flag,
  input wire [11:0] data_o,
  input wire [11:0] data_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  wire        go = chip_en & !chip_sel_n & !read_conv;
  wire        rd = chip_en & !chip_sel_n & read_conv;
  reg  [11:0] n_r;
  reg         s_r;
  // Cycle kind frozen while busy, pin held by host
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      n_r <= 12'h000;
      s_r <= 1'b0;
    end else begin
      n_r <= conv_busy_flag ? n_r + 12'h001 : 12'h000;
      if (!conv_busy_flag) s_r <= byte_short_select;
    end
  end
  start_busy_a: assert property ($rose(go) && !conv_busy_flag |-> ##[1:4] conv_busy_flag)
    else $error("no busy after start");
  full_len_a: assert property (conv_busy_flag |-> n_r < 12'hdac)
    else $error("full conversion too long");
  short_len_a: assert property (conv_busy_flag && s_r |-> n_r < 12'h960)
    else $error("short conversion too long");
  busy_oe_a: assert property (conv_busy_flag |-> data_oe == 12'h000)
    else $error("drivers on while busy");
  read_on_a: assert property ((rd && !conv_busy_flag) [*5] |-> data_oe[11])
    else $error("read not driven");
  idle_off_a: assert property ((!rd) [*5] |-> data_oe == 12'h000)
    else $error("drivers on without read");
  word_oe_a: assert property (data_oe[11] && word_mode |-> data_oe == 12'hfff)
    else $error("word read not on all lines");
  byte_oe_a: assert property (data_oe[11] && !word_mode |-> data_oe == 12'hff0)
    else $error("byte read on wrong lines");
  data_hold_a: assert property (data_oe[11] && $past(data_oe[11]) |-> $stable(data_o))
    else $error("data changed during read");
endmodule
bind abc_ctrl abc_ctrl_sva u_sva (.clk, .nrst, .chip_en, .chip_sel_n, .read_conv,
  .byte_short_select, .word_mode, .analog_code, .conv_busy_flag, .data_o, .data_oe);
`default_nettype wire

// file: abc_host.sv
// Host bus model driving the converter's control pins.
// Assumes pins change only at the falling clock edge.
`timescale 1ns/1ps
`default_nettype none
module abc_host (
  input  wire clk,
  output reg  chip_en,
  output reg  chip_sel_n,
  output reg  read_conv,
  output reg  byte_short_select
);
  initial {chip_en, chip_sel_n, read_conv, byte_short_select} = 4'h4;
  task bus(input r, a, s, on);
    @(negedge clk);
    if (on) {read_conv, byte_short_select} = {r, a};
    if (s) chip_en = on;
    else chip_sel_n = !on;
    @(negedge clk);
    if (s) chip_sel_n = !on;
    else chip_en = on;
  endtask
endmodule
`default_nettype wire

// file: abc_tb.sv
// Self-checking bench: conversions, refused starts, byte and word reads.
// Assumes the host model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  reg         clk = 0, nrst = 0, word_mode = 0, sh = 0;
  reg  [11:0] analog_code = 12'h000;
  reg  [15:0] s = 16'h0027;
  wire        chip_en, chip_sel_n, read_conv, byte_short_select, conv_busy_flag;
  wire [11:0] data_o, data_oe;
  integer     failures = 0, total_checks = 0, cyc = 0, i, k, n;
  abc_host u_h (.clk, .chip_en, .chip_sel_n, .read_conv, .byte_short_select);
  abc_ctrl u_dut (.clk, .nrst, .chip_en, .chip_sel_n, .read_conv, .byte_short_select,
    .word_mode, .analog_code, .conv_busy_flag, .data_o, .data_oe);
  always #5 clk = ~clk;
  // Hang guard well above four full conversions
  always @(posedge clk) if (++cyc > 40000) begin
    failures++;
    test_done;
  end
  function [15:0] xs(input [15:0] x);
    x = x ^ (x << 7);
    x = x ^ (x >> 9);
    xs = x ^ (x << 8);
  endfunction
  function [11:0] ex(input [11:0] c, input h, w, a);
    ex = h ? {c[11:4], 4'h0} : c;
    if (!w) ex = a ? {ex[3:0], 8'h00} : {ex[11:4], 4'h0};
  endfunction
  task chk(input [11:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task test_done;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task rd(input a);
    u_h.bus(1, a, 0, 1);
    repeat (5) @(negedge clk);
    chk(data_o & data_oe, ex(analog_code, sh, word_mode, a));
    u_h.bus(1, a, 0, 0);
    repeat (5) @(negedge clk);
    chk(data_oe, 12'h000);
  endtask
  initial begin
    repeat (20) @(negedge clk);
    nrst = 1;
    chk(conv_busy_flag, 12'h000);
    for (i = 0; i < 4; i++) begin
      s = xs(s);
      analog_code = s[11:0];
      word_mode = i[0];
      sh = i[1];
      u_h.bus(0, sh, i == 3, 1);
      for (n = 0; n < 9 && !conv_busy_flag; n++) @(negedge clk);
      chk(conv_busy_flag, 12'h001);
      u_h.bus(0, sh, 0, 0);
      u_h.bus(0, sh, 0, 1);
      u_h.bus(1, sh, 0, 0);
      u_h.bus(1, sh, 0, 1);
      repeat (5) @(negedge clk);
      chk(data_oe, 12'h000);
      u_h.bus(1, sh, 0, 0);
      // Busy seen on sixteen edges so far; k ends at the busy length
      for (k = 15; k < 4000 && conv_busy_flag; k++) @(negedge clk);
      chk(k <= (sh ? 2400 : 3500), 12'h001);
      rd(0);
      if (!word_mode) rd(1);
    end
    test_done;
  end
endmodule
`default_nettype wire
